/* verilog/usbsd_ctrl.sv */
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "usbsd_regs.svh"

module usbsd_ctrl
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   tok_valid_i,
  input  wire usbsd_pkg::usbsd_pid_t  tok_pid_i,
  input  wire logic [1:0]             tok_ep_i,
  input  wire logic                   rx_valid_i,
  input  wire logic [7:0]             rx_data_i,
  input  wire logic                   rx_end_i,
  input  wire logic                   rx_abort_i,
  input  wire logic                   feat_set_i,
  input  wire logic                   feat_clr_i,
  input  wire logic [1:0]             feat_ep_i,
  input  wire logic                   viol_i,
  input  wire logic [1:0]             viol_ep_i,
  input  wire logic                   tx_rd_i,
  input  wire logic                   tx_ack_i,
  input  wire logic                   vbus_i,
  output logic                        hs_valid_o,
  output usbsd_pkg::usbsd_hs_t        hs_code_o,
  output logic      [7:0]             tx_data_o,
  output logic      [6:0]             tx_len_o,
  output logic                        dma_req1_o,
  output logic                        dma_req2_o,
  output logic                        pullup_o
);
  import usbsd_pkg::*;

  logic [2:0]      dma_set_reg;
  logic [3:0]      app_stall_request_bits;
  logic [3:0]      stall_bits_reg;
  logic            xfer_req_flag_reg;
  logic            xfer_req_pend_reg;
  logic            setup_abort_reg;
  logic            setup_busy_reg;
  logic            setup_rdy_reg;
  logic [7:0]      setup_mem_reg [0:7];
  logic [2:0]      setup_widx_reg;
  logic [2:0]      setup_ridx_reg;
  logic [1:0]      rx_tgt_reg;
  usbsd_tx_state_t tx_state_reg;
  logic            wb_hit;
  logic            wr_hit;
  logic            rd_hit;
  logic            byte_acc;
  logic [3:0]      trig;
  logic            tok_norm;
  logic            setup0;
  logic            ep1_commit;
  logic            ep1_discard;
  logic            ep1_release;
  logic            ep2_commit;
  logic            ep2_release;
  logic [7:0]      ep1_rd_data;
  logic            ep1_rd_valid;
  logic [6:0]      ep1_rd_left;
  logic            ep1_wr_free;
  logic [6:0]      ep1_wr_cnt;
  logic [7:0]      ep2_rd_data;
  logic            ep2_rd_valid;
  logic [6:0]      ep2_rd_left;
  logic            ep2_wr_free;
  logic [6:0]      ep2_wr_cnt;
  logic [31:0]     status;

  // Bus decode: one access taken per request, answered next cycle
  assign wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_hit   = wb_hit && wb_we_i;
  assign rd_hit   = wb_hit && !wb_we_i;
  assign byte_acc = (wb_sel_i == `USBSD_BYTE_SEL);
  assign trig     = (wr_hit && wb_adr_i == `USBSD_OFS_EP_TRIGGER) ? wb_dat_i[3:0] : 4'h0;

  // Token classification
  assign setup0   = tok_valid_i && tok_pid_i == USBSD_PID_SETUP && tok_ep_i == 2'h0;
  assign tok_norm = tok_valid_i && !setup0;

  // Endpoint 1 buffer control
  assign ep1_commit  = rx_end_i && rx_tgt_reg == 2'h1 && !(dma_set_reg[`USBSD_DMA_EP1_EN] && ep1_wr_cnt == 7'h00);
  assign ep1_discard = (rx_end_i || rx_abort_i) && rx_tgt_reg == 2'h1 && !ep1_commit;
  assign ep1_release = dma_set_reg[`USBSD_DMA_EP1_EN] ? (ep1_rd_valid && ep1_rd_left == 7'h00)
                                                      : trig[`USBSD_TRG_EP1_DONE];

  // Endpoint 2 buffer control
  assign ep2_commit  = trig[`USBSD_TRG_EP2_READY] || (dma_set_reg[`USBSD_DMA_EP2_EN] && ep2_wr_free
                       && ep2_wr_cnt == `USBSD_PKT_MAX);
  assign ep2_release = tx_ack_i && tx_state_reg == USBSD_TX_BUSY;

  usbsd_pingpong u_ep1
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clear_i    (trig[`USBSD_TRG_EP1_CLR] && !dma_set_reg[`USBSD_DMA_EP1_EN]),
    .wr_en_i    (rx_valid_i && rx_tgt_reg == 2'h1),
    .wr_data_i  (rx_data_i),
    .commit_i   (ep1_commit),
    .discard_i  (ep1_discard),
    .rd_en_i    (rd_hit && byte_acc && wb_adr_i == `USBSD_OFS_EP1_DATA),
    .release_i  (ep1_release),
    .rd_data_o  (ep1_rd_data),
    .rd_valid_o (ep1_rd_valid),
    .rd_left_o  (ep1_rd_left),
    .wr_free_o  (ep1_wr_free),
    .wr_cnt_o   (ep1_wr_cnt)
  );

  usbsd_pingpong u_ep2
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clear_i    (trig[`USBSD_TRG_EP2_CLR]),
    .wr_en_i    (wr_hit && byte_acc && wb_adr_i == `USBSD_OFS_EP2_DATA),
    .wr_data_i  (wb_dat_i[7:0]),
    .commit_i   (ep2_commit),
    .discard_i  (1'b0),
    .rd_en_i    (tx_rd_i && tx_state_reg == USBSD_TX_BUSY),
    .release_i  (ep2_release),
    .rd_data_o  (ep2_rd_data),
    .rd_valid_o (ep2_rd_valid),
    .rd_left_o  (ep2_rd_left),
    .wr_free_o  (ep2_wr_free),
    .wr_cnt_o   (ep2_wr_cnt)
  );

  // Software-written control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dma_set_reg            <= `USBSD_DMA_RST;
      app_stall_request_bits <= `USBSD_STALL_RST;
    end
    else if (wr_hit && wb_adr_i == `USBSD_OFS_DMA_SETTING)
    begin
      dma_set_reg <= wb_dat_i[2:0];
    end
    else if (wr_hit && wb_adr_i == `USBSD_OFS_STALL_REQ)
    begin
      app_stall_request_bits <= wb_dat_i[3:0];
    end
  end

  // Internal stall bits; any set wins over a clear
  for (genvar e = 0; e < 4; e++)
  begin : g_stall
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        stall_bits_reg[e] <= 1'b0;
      end
      else if ((feat_set_i && feat_ep_i == 2'(e)) || (viol_i && viol_ep_i == 2'(e)))
      begin
        stall_bits_reg[e] <= 1'b1;
      end
      else if (tok_norm && tok_ep_i == 2'(e) && app_stall_request_bits[e])
      begin
        stall_bits_reg[e] <= 1'b1;
      end
      else if ((e == 0) ? setup0 : (feat_clr_i && feat_ep_i == 2'(e)))
      begin
        stall_bits_reg[e] <= 1'b0;
      end
    end
  end

  // Token answer, receive target and transmit state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hs_valid_o        <= 1'b0;
      hs_code_o         <= USBSD_HS_ACK;
      rx_tgt_reg        <= 2'h0;
      xfer_req_pend_reg <= 1'b0;
      tx_state_reg      <= USBSD_TX_IDLE;
      tx_len_o          <= 7'h00;
    end
    else
    begin
      hs_valid_o        <= tok_valid_i;
      xfer_req_pend_reg <= 1'b0;
      if (rx_end_i || rx_abort_i)
      begin
        rx_tgt_reg <= 2'h0;
      end
      if (ep2_release)
      begin
        tx_state_reg <= USBSD_TX_IDLE;
      end
      if (setup0)
      begin
        hs_code_o  <= USBSD_HS_ACK;
        rx_tgt_reg <= 2'h0;
      end
      else if (tok_valid_i && (stall_bits_reg[tok_ep_i] || app_stall_request_bits[tok_ep_i]))
      begin
        hs_code_o <= USBSD_HS_STALL;
      end
      else if (tok_valid_i && tok_ep_i == 2'h1 && tok_pid_i == USBSD_PID_OUT)
      begin
        hs_code_o  <= ep1_wr_free ? USBSD_HS_ACK : USBSD_HS_NAK;
        rx_tgt_reg <= ep1_wr_free ? 2'h1 : 2'h0;
      end
      else if (tok_valid_i && tok_ep_i == 2'h2 && tok_pid_i == USBSD_PID_IN)
      begin
        case (tx_state_reg)
          USBSD_TX_IDLE:
          begin
            if (ep2_rd_valid)
            begin
              hs_code_o    <= USBSD_HS_DATA;
              tx_len_o     <= ep2_rd_left;
              tx_state_reg <= USBSD_TX_BUSY;
            end
            else
            begin
              hs_code_o         <= USBSD_HS_NAK;
              xfer_req_pend_reg <= 1'b1;
            end
          end
          default:
          begin
            hs_code_o <= USBSD_HS_NAK;
          end
        endcase
      end
      else if (tok_valid_i)
      begin
        hs_code_o <= USBSD_HS_ACK;
      end
    end
  end

  // Transmit byte out to the protocol engine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_data_o <= 8'h00;
    end
    else if (tx_rd_i && tx_state_reg == USBSD_TX_BUSY)
    begin
      tx_data_o <= ep2_rd_data;
    end
  end

  // Setup buffer: USB writes win over CPU reads
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setup_widx_reg <= 3'h0;
      setup_ridx_reg <= 3'h0;
      setup_busy_reg <= 1'b0;
      setup_rdy_reg  <= 1'b0;
    end
    else if (setup0)
    begin
      setup_widx_reg <= 3'h0;
      setup_ridx_reg <= 3'h0;
      setup_busy_reg <= 1'b1;
      setup_rdy_reg  <= 1'b0;
    end
    else if (setup_busy_reg)
    begin
      if (rx_valid_i)
      begin
        setup_mem_reg[setup_widx_reg] <= rx_data_i;
        setup_widx_reg                <= setup_widx_reg + 3'h1;
      end
      if (rx_end_i || rx_abort_i)
      begin
        setup_busy_reg <= 1'b0;
        setup_rdy_reg  <= rx_end_i;
      end
    end
    else if (rd_hit && wb_adr_i == `USBSD_OFS_SETUP_DATA)
    begin
      setup_ridx_reg <= setup_ridx_reg + 3'h1;
      if (setup_ridx_reg == `USBSD_SETUP_LAST)
      begin
        setup_rdy_reg <= 1'b0;
      end
    end
  end

  // Sticky flags, cleared by writing one to status; a set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xfer_req_flag_reg <= 1'b0;
      setup_abort_reg   <= 1'b0;
    end
    else
    begin
      if (xfer_req_pend_reg)
      begin
        xfer_req_flag_reg <= 1'b1;
      end
      else if (wr_hit && wb_adr_i == `USBSD_OFS_STATUS && wb_dat_i[`USBSD_ST_XFER_REQ])
      begin
        xfer_req_flag_reg <= 1'b0;
      end
      if ((setup0 && setup_ridx_reg != 3'h0)
          || (setup_busy_reg && rd_hit && wb_adr_i == `USBSD_OFS_SETUP_DATA))
      begin
        setup_abort_reg <= 1'b1;
      end
      else if (wr_hit && wb_adr_i == `USBSD_OFS_STATUS && wb_dat_i[`USBSD_ST_SETUP_ABORT])
      begin
        setup_abort_reg <= 1'b0;
      end
    end
  end

  // DMA requests and pull-up pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dma_req1_o <= 1'b0;
      dma_req2_o <= 1'b0;
      pullup_o   <= 1'b0;
    end
    else
    begin
      dma_req1_o <= dma_set_reg[`USBSD_DMA_EP1_EN] && ep1_rd_left != 7'h00;
      dma_req2_o <= dma_set_reg[`USBSD_DMA_EP2_EN] && ep2_wr_free && ep2_wr_cnt < `USBSD_PKT_MAX;
      pullup_o   <= dma_set_reg[`USBSD_DMA_PULLUP] && vbus_i;
    end
  end

  // Status word
  always_comb
  begin
    status                                           = 32'h0000_0000;
    status[3:0]                                      = stall_bits_reg;
    status[`USBSD_ST_XFER_REQ]                       = xfer_req_flag_reg;
    status[`USBSD_ST_SETUP_ABORT]                    = setup_abort_reg;
    status[`USBSD_ST_VBUS]                           = vbus_i;
    status[`USBSD_ST_SETUP_RDY]                      = setup_rdy_reg;
    status[`USBSD_ST_LEFT_MSB:`USBSD_ST_LEFT_LSB]    = ep1_rd_left;
  end

  // Bus answer; unmapped or write-only offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      if (rd_hit)
      begin
        case (wb_adr_i)
          `USBSD_OFS_DMA_SETTING: wb_dat_o <= {29'h000_0000, dma_set_reg};
          `USBSD_OFS_STALL_REQ:   wb_dat_o <= {28'h000_0000, app_stall_request_bits};
          `USBSD_OFS_STATUS:      wb_dat_o <= status;
          `USBSD_OFS_EP1_DATA:    wb_dat_o <= {24'h00_0000, (byte_acc && ep1_rd_left != 7'h00) ? ep1_rd_data : 8'h00};
          `USBSD_OFS_SETUP_DATA:  wb_dat_o <= {24'h00_0000, setup_busy_reg ? 8'h00 : setup_mem_reg[setup_ridx_reg]};
          default:                wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_FEATURE_STALL: assert property (feat_set_i |=> stall_bits_reg[$past(feat_ep_i)])
    else $error("set-feature did not set stall bit");
  AST_STALL_HOLDS: assert property (stall_bits_reg[1] && !(feat_clr_i && feat_ep_i == 2'h1) |=> stall_bits_reg[1])
    else $error("stall bit dropped without clear-feature");
  AST_RECHECK: assert property (tok_norm && tok_ep_i == 2'h1 && app_stall_request_bits[1] |=> stall_bits_reg[1])
    else $error("app stall request not applied after clear");
  AST_APP_STALL: assert property (tok_norm && app_stall_request_bits[tok_ep_i]
                                  |=> hs_valid_o && hs_code_o == USBSD_HS_STALL)
    else $error("stall handshake missing");
  AST_EP0_CLEAR: assert property (setup0 && !(feat_set_i && feat_ep_i == 2'h0) && !(viol_i && viol_ep_i == 2'h0)
                                  |=> !stall_bits_reg[0])
    else $error("setup did not clear endpoint 0 stall");
  AST_DMA1_REQ: assert property (dma_set_reg[`USBSD_DMA_EP1_EN] && ep1_rd_left != 7'h00 |=> dma_req1_o)
    else $error("endpoint 1 DMA request missing");
  AST_DMA2_REQ: assert property (!dma_set_reg[`USBSD_DMA_EP2_EN] |=> !dma_req2_o)
    else $error("endpoint 2 DMA request while disabled");
  AST_ZLP_DROP: assert property (rx_end_i && rx_tgt_reg == 2'h1 && dma_set_reg[`USBSD_DMA_EP1_EN]
                                 && ep1_wr_cnt == 7'h00 |-> !ep1_commit)
    else $error("zero-length packet kept under DMA");
  AST_AUTO_DONE: assert property (dma_set_reg[`USBSD_DMA_EP1_EN] && ep1_rd_valid && ep1_rd_left == 7'h00
                                  |=> !ep1_rd_valid || ep1_rd_left != 7'h00)
    else $error("empty endpoint 1 bank not released");
  AST_AUTO_PKT: assert property (dma_set_reg[`USBSD_DMA_EP2_EN] && ep2_wr_free && ep2_wr_cnt == `USBSD_PKT_MAX
                                 |=> ep2_wr_cnt == 7'h00 && ep2_rd_valid)
    else $error("full endpoint 2 bank not committed");
  AST_PULLUP: assert property (!vbus_i |=> !pullup_o)
    else $error("pull-up driven without bus power");
  AST_SETUP_ABORT: assert property (setup0 && setup_ridx_reg != 3'h0 |=> setup_abort_reg)
    else $error("interrupted setup read not flagged");
  AST_NAK_THEN_FLAG: assert property (tok_valid_i && tok_pid_i == USBSD_PID_IN && tok_ep_i == 2'h2 && xfer_req_pend_reg == 1'b0
                                      && !ep2_rd_valid && tx_state_reg == USBSD_TX_IDLE
                                      && !stall_bits_reg[2] && !app_stall_request_bits[2]
                                      |=> hs_code_o == USBSD_HS_NAK ##2 xfer_req_flag_reg)
    else $error("transfer request flag not set after NAK");

  COV_STALL: cover property (tok_norm ##1 hs_code_o == USBSD_HS_STALL);
  COV_AUTO_DONE: cover property (ep1_release && dma_set_reg[`USBSD_DMA_EP1_EN]);
  COV_AUTO_PKT: cover property (ep2_commit && dma_set_reg[`USBSD_DMA_EP2_EN]);
  COV_SETUP_ABORT: cover property ($rose(setup_abort_reg));

endmodule : usbsd_ctrl

/* verilog/usbsd_regs.svh */
`ifndef USBSD_REGS_SVH
`define USBSD_REGS_SVH

// Byte offsets on the register bus
`define USBSD_OFS_DMA_SETTING 8'h00
`define USBSD_OFS_EP_TRIGGER  8'h04
`define USBSD_OFS_STALL_REQ   8'h08
`define USBSD_OFS_STATUS      8'h0C
`define USBSD_OFS_EP1_DATA    8'h10
`define USBSD_OFS_EP2_DATA    8'h14
`define USBSD_OFS_SETUP_DATA  8'h18

// DMA setting register fields and reset value
`define USBSD_DMA_EP1_EN 0
`define USBSD_DMA_EP2_EN 1
`define USBSD_DMA_PULLUP 2
`define USBSD_DMA_RST    3'h0

// Endpoint trigger register fields (write-only pulses)
`define USBSD_TRG_EP1_DONE  0
`define USBSD_TRG_EP2_READY 1
`define USBSD_TRG_EP1_CLR   2
`define USBSD_TRG_EP2_CLR   3

// Status register fields; stall bits sit in [3:0]
`define USBSD_ST_XFER_REQ    4
`define USBSD_ST_SETUP_ABORT 5
`define USBSD_ST_VBUS        6
`define USBSD_ST_SETUP_RDY   7
`define USBSD_ST_LEFT_LSB    8
`define USBSD_ST_LEFT_MSB    14

// Sizes and reset values
`define USBSD_STALL_RST  4'h0
`define USBSD_PKT_MAX    7'h40
`define USBSD_SETUP_LAST 3'h7
`define USBSD_BYTE_SEL   4'h1

`endif

/* verilog/usbsd_pkg.sv */
package usbsd_pkg;

  // Token kinds from the protocol engine
  typedef enum logic [1:0] {
    USBSD_PID_OUT   = 2'h0,
    USBSD_PID_IN    = 2'h1,
    USBSD_PID_SETUP = 2'h2
  } usbsd_pid_t;

  // Handshake answers to a token
  typedef enum logic [1:0] {
    USBSD_HS_ACK   = 2'h0,
    USBSD_HS_NAK   = 2'h1,
    USBSD_HS_STALL = 2'h2,
    USBSD_HS_DATA  = 2'h3
  } usbsd_hs_t;

  // Bulk-in transmit states, one-hot
  typedef enum logic [1:0] {
    USBSD_TX_IDLE = 2'h1,
    USBSD_TX_BUSY = 2'h2
  } usbsd_tx_state_t;

endpackage : usbsd_pkg

/* verilog/usbsd_pingpong.sv */
`timescale 1ns/100ps
`include "usbsd_regs.svh"

module usbsd_pingpong
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       commit_i,
  input  wire logic       discard_i,
  input  wire logic       rd_en_i,
  input  wire logic       release_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  output logic      [6:0] rd_left_o,
  output logic            wr_free_o,
  output logic      [6:0] wr_cnt_o
);

  logic [7:0] mem_reg [0:127];
  logic [1:0] valid_reg;
  logic [6:0] len_reg [0:1];
  logic       wsel_reg;
  logic       rsel_reg;
  logic [6:0] wptr_reg;
  logic [6:0] rptr_reg;
  logic       wr_ok;
  logic       rd_ok;

  // Writes stop at one packet; reads stop at the received size
  assign wr_ok = wr_en_i && !valid_reg[wsel_reg] && (wptr_reg < `USBSD_PKT_MAX);
  assign rd_ok = rd_en_i && valid_reg[rsel_reg] && (rptr_reg < len_reg[rsel_reg]);

  // Byte storage, both banks in one array
  always_ff @(posedge clk_i)
  begin
    if (wr_ok)
    begin
      mem_reg[{wsel_reg, wptr_reg[5:0]}] <= wr_data_i;
    end
  end

  // Fill side: commit hands the bank over and moves to the other one
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      wsel_reg <= 1'b0;
      wptr_reg <= 7'h00;
    end
    else if (commit_i && !valid_reg[wsel_reg])
    begin
      wsel_reg <= ~wsel_reg;
      wptr_reg <= 7'h00;
    end
    else if (discard_i)
    begin
      wptr_reg <= 7'h00;
    end
    else if (wr_ok)
    begin
      wptr_reg <= wptr_reg + 7'h01;
    end
  end

  // Drain side: release frees the bank and switches
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      rsel_reg <= 1'b0;
      rptr_reg <= 7'h00;
    end
    else if (release_i && valid_reg[rsel_reg])
    begin
      rsel_reg <= ~rsel_reg;
      rptr_reg <= 7'h00;
    end
    else if (rd_ok)
    begin
      rptr_reg <= rptr_reg + 7'h01;
    end
  end

  // Per-bank valid flag and packet length
  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    always_ff @(posedge clk_i)
    begin
      if (rst_i || clear_i)
      begin
        valid_reg[b] <= 1'b0;
        len_reg[b]   <= 7'h00;
      end
      else if (release_i && valid_reg[b] && (rsel_reg == 1'(b)))
      begin
        valid_reg[b] <= 1'b0;
      end
      else if (commit_i && !valid_reg[b] && (wsel_reg == 1'(b)))
      begin
        valid_reg[b] <= 1'b1;
        len_reg[b]   <= wptr_reg;
      end
    end
  end

  // Views of the current banks
  assign rd_data_o  = mem_reg[{rsel_reg, rptr_reg[5:0]}];
  assign rd_valid_o = valid_reg[rsel_reg];
  assign rd_left_o  = valid_reg[rsel_reg] ? (len_reg[rsel_reg] - rptr_reg) : 7'h00;
  assign wr_free_o  = !valid_reg[wsel_reg];
  assign wr_cnt_o   = wptr_reg;

endmodule : usbsd_pingpong

/* test/usbsd_host_model.sv */
`timescale 1ns/100ps
// Engine side of the link: tokens and received bytes
module usbsd_host_model
(
  input  wire logic             clk_i,
  output logic                  tok_o,
  output usbsd_pkg::usbsd_pid_t pid_o,
  output logic [1:0]            ep_o,
  output logic                  rxv_o,
  output logic [7:0]            rxd_o,
  output logic                  end_o
);
  import usbsd_pkg::*;
  // Idle levels at time zero
  initial
  begin
    {tok_o, ep_o, rxv_o, rxd_o, end_o} = '0;
    pid_o = USBSD_PID_OUT;
  end
  // One-cycle token pulse
  task tok(input usbsd_pid_t p, input logic [1:0] e);
    @(posedge clk_i);
    tok_o <= 1'b1;
    pid_o <= p;
    ep_o <= e;
    @(posedge clk_i);
    tok_o <= 1'b0;
  endtask : tok
  // One byte or packet end; released data shows the inverse
  task rx(input logic [7:0] b, input logic last);
    @(posedge clk_i);
    rxv_o <= !last;
    end_o <= last;
    rxd_o <= b;
    @(posedge clk_i);
    {rxv_o, end_o} <= 2'h0;
    rxd_o <= ~b;
  endtask : rx
endmodule : usbsd_host_model

/* test/tb_usbsd_ctrl.sv */
`timescale 1ns/100ps
`include "usbsd_regs.svh"
module tb_usbsd_ctrl;
  import usbsd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, vbus = 1'b0, fs = 1'b0, fc = 1'b0, vi = 1'b0;
  logic ack, hsv, tv, rxv, rxe, req1, req2, pu;
  logic [1:0] fe = 2'h0, te;
  logic [7:0] adr = 8'h00, rxd, q[$];
  logic [31:0] dat = 32'h0, rdo, rdata;
  logic [6:0] tlen;
  logic [3:0] st_m = 4'h0, app_m = 4'h0;
  usbsd_pid_t tp;
  usbsd_hs_t hs;
  int errors = 0, check_count = 0, cycles = 0, n, seed;
  // Clock
  always #2.5 clk_i = ~clk_i;
  usbsd_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(`USBSD_BYTE_SEL), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .tok_valid_i(tv), .tok_pid_i(tp),
    .tok_ep_i(te), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_end_i(rxe), .rx_abort_i(1'b0), .feat_set_i(fs),
    .feat_clr_i(fc), .feat_ep_i(fe), .viol_i(vi), .viol_ep_i(fe), .tx_rd_i(1'b0), .tx_ack_i(1'b0), .vbus_i(vbus),
    .hs_valid_o(hsv), .hs_code_o(hs), .tx_data_o(), .tx_len_o(tlen), .dma_req1_o(req1), .dma_req2_o(req2),
    .pullup_o(pu));
  usbsd_host_model host_u (.clk_i(clk_i), .tok_o(tv), .pid_o(tp), .ep_o(te), .rxv_o(rxv), .rxd_o(rxd), .end_o(rxe));
  // Compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Single Wishbone cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i iff ack);
    rdata = rdo;
    cyc <= 1'b0;
  endtask : wb
  // Token against the stall model
  task tok(input usbsd_pid_t p, input logic [1:0] e, input usbsd_hs_t ok);
    if (p == USBSD_PID_SETUP)
      st_m[0] = 1'b0;
    else if (st_m[e] | app_m[e])
    begin
      st_m[e] = 1'b1;
      ok = USBSD_HS_STALL;
    end
    host_u.tok(p, e);
    @(negedge clk_i);
    chk({hsv, hs}, {1'b1, ok});
  endtask : tok
  // Feature set, clear or violation
  task ev(input logic s, input logic c, input logic [1:0] e);
    @(posedge clk_i);
    fs <= s;
    fc <= c;
    vi <= !s & !c;
    fe <= e;
    @(posedge clk_i);
    {fs, fc, vi} <= 3'h0;
    st_m[e] = !c;
  endtask : ev
  // Random packet into the queue
  task pkt(input int k);
    repeat (k)
    begin
      q.push_back(8'($urandom));
      host_u.rx(q[$], 1'b0);
    end
    host_u.rx(8'h00, 1'b1);
  endtask : pkt
  // Read bytes against the queue
  task pop(input logic [7:0] a, input int k);
    repeat (k)
    begin
      wb(1'b0, a, 32'h0);
      chk(rdata[7:0], q.pop_front());
    end
  endtask : pop
  // Verdict
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      report_and_stop;
    end
  end
  // Main sequence
  initial
  begin
    seed = $urandom(92);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `USBSD_OFS_DMA_SETTING, 32'h0);
    chk(rdata, `USBSD_DMA_RST);
    wb(1'b1, `USBSD_OFS_STALL_REQ, 32'h4);
    app_m = 4'h4;
    tok(USBSD_PID_IN, 2'h2, USBSD_HS_NAK);
    wb(1'b1, `USBSD_OFS_STALL_REQ, 32'h0);
    app_m = 4'h0;
    wb(1'b1, `USBSD_OFS_STATUS, 32'hF);
    tok(USBSD_PID_IN, 2'h2, USBSD_HS_NAK);
    ev(1'b0, 1'b1, 2'h2);
    tok(USBSD_PID_IN, 2'h2, USBSD_HS_NAK);
    wb(1'b0, `USBSD_OFS_STATUS, 32'h0);
    chk(rdata[4], 1'b1);
    ev(1'b1, 1'b0, 2'h3);
    tok(USBSD_PID_OUT, 2'h3, USBSD_HS_ACK);
    wb(1'b1, `USBSD_OFS_STALL_REQ, 32'h8);
    app_m = 4'h8;
    ev(1'b0, 1'b1, 2'h3);
    tok(USBSD_PID_OUT, 2'h3, USBSD_HS_ACK);
    ev(1'b0, 1'b0, 2'h0);
    tok(USBSD_PID_IN, 2'h0, USBSD_HS_NAK);
    $display("test stall done");
    tok(USBSD_PID_SETUP, 2'h0, USBSD_HS_ACK);
    pkt(8);
    wb(1'b0, `USBSD_OFS_STATUS, 32'h0);
    chk(rdata[3:0], st_m);
    pop(`USBSD_OFS_SETUP_DATA, 8);
    wb(1'b1, `USBSD_OFS_DMA_SETTING, 32'h5);
    chk(pu, 1'b0);
    vbus <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk(pu, 1'b1);
    tok(USBSD_PID_OUT, 2'h1, USBSD_HS_ACK);
    pkt(0);
    n = 1 + $urandom_range(63);
    tok(USBSD_PID_OUT, 2'h1, USBSD_HS_ACK);
    pkt(n);
    wb(1'b0, `USBSD_OFS_STATUS, 32'h0);
    chk(rdata[14:8], n[6:0]);
    chk(req1, 1'b1);
    pop(`USBSD_OFS_EP1_DATA, n);
    repeat (2) @(negedge clk_i);
    chk(req1, 1'b0);
    wb(1'b1, `USBSD_OFS_DMA_SETTING, 32'h6);
    repeat (2) @(negedge clk_i);
    chk(req2, 1'b1);
    repeat (64) wb(1'b1, `USBSD_OFS_EP2_DATA, 32'($urandom_range(255)));
    tok(USBSD_PID_IN, 2'h2, USBSD_HS_DATA);
    chk(tlen, `USBSD_PKT_MAX);
    chk(req2, 1'b1);
    wb(1'b1, `USBSD_OFS_DMA_SETTING, 32'h4);
    repeat (2) @(negedge clk_i);
    chk(req2, 1'b0);
    $display("test dma done");
    report_and_stop;
  end
endmodule : tb_usbsd_ctrl
